// [rtl/duhbp_pkg.sv]
// Purpose: shared types and constants for the dual channel host bus port
// Assumes: pins already synchronous to clk
// Notes: none
package duhbp_pkg;

  localparam int ADDR_WIDTH = 3;
  localparam int DATA_WIDTH = 8;
  localparam logic BUS_STROBE = 1'b1;
  localparam logic DIR_READ = 1'b1;
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    DUHBP_IDLE = 3'b001,
    DUHBP_READ = 3'b010,
    DUHBP_WRITE = 3'b100
  } duhbp_state_type;

  // one access request towards a channel
  typedef struct packed {
    logic chan;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } duhbp_access_type;

  // per channel status from the uart core
  typedef struct packed {
    logic irq;
    logic irq_output_enable_bit;
    logic tx_ready;
    logic rx_ready;
  } duhbp_chan_status_type;

endpackage : duhbp_pkg

// [rtl/duhbp_edge.sv]
// Purpose: rise and fall pulse detector for one strobe level
// Assumes: input already synchronous
// Notes: idle level given by parameter
`timescale 1ns/100ps
module duhbp_edge #(
  parameter logic IDLE = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic level,
  output logic fall,
  output logic rise
);

  logic last;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last <= IDLE;
    end else begin
      last <= level;
    end
  end

  assign fall = last & ~level;
  assign rise = ~last & level;

endmodule : duhbp_edge

// [rtl/duhbp_irq_out.sv]
// Purpose: one channel interrupt pin and its auxiliary output
// Assumes: enable bit comes from the channel control register
// Notes: open drain mode only pulls low
`timescale 1ns/100ps
module duhbp_irq_out (
  input wire logic open_drain,
  input wire logic irq,
  input wire logic irq_output_enable_bit,
  output logic irq_out,
  output logic irq_oe,
  output logic aux_out_n
);

  // open drain: low when interrupt pending, else released
  assign irq_out = open_drain ? 1'b0 : irq;
  assign irq_oe = open_drain ? irq : irq_output_enable_bit;
  assign aux_out_n = ~irq_output_enable_bit;

endmodule : duhbp_irq_out

// [rtl/duhbp_port.sv]
// Purpose: host bus port of a dual channel uart, two bus styles
// Assumes: all pins synchronous to clk; core answers reads combinationally
// Notes: bus style pin static; data bus split into in/out/enable
//
// Operation
// [RULE1] style pin high selects strobe bus, low selects read/write-line bus
// [RULE2] strobe style: read strobe fall reads addressed register onto data bus
// [RULE3] host captures read byte at read strobe rising edge
// [RULE4] read/write-line style: host holds read strobe high, device ignores it
// [RULE5] strobe style: write strobe fall begins internal write cycle
// [RULE6] write strobe rise loads data bus byte into addressed register
// [RULE7] read/write-line style: write strobe pin high reads, low writes
// [RULE8] strobe style: channel A select low enables channel A access
// [RULE9] strobe style: channel B select low enables channel B access
// [RULE10] read/write-line style: channel A select is the single device select
// [RULE11] read/write-line style: channel B select pin is channel bit, 1 is B
// [RULE12] strobe style: channel A irq driven when enable bit 1, aux low
// [RULE13] read/write-line style: channel A irq is shared open-drain, active low
// [RULE14] channel B irq driven when enable bit 1, aux low, else tristate
// [RULE15] enable bit resets to 0: irq tristated, aux high
// [RULE16] per channel active-low transmit ready reflects transmit state
// [RULE17] per channel active-low receive ready reflects receive state
// [RULE18] three address lines pick register in addressed channel
// [RULE19] one bidirectional eight bit data bus shared by both parties
// [RULE20] style pin fixed during operation
// [RULE21] ready conditions come from core fifo mode logic
`timescale 1ns/100ps
module duhbp_port #(
  parameter int ADDR_WIDTH = duhbp_pkg::ADDR_WIDTH,
  parameter int DATA_WIDTH = duhbp_pkg::DATA_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_style,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] data_in,
  output logic [DATA_WIDTH-1:0] data_out,
  output logic data_oe,
  output logic core_read,
  output logic core_write,
  output duhbp_pkg::duhbp_access_type core_access,
  input wire logic [DATA_WIDTH-1:0] core_read_data_a,
  input wire logic [DATA_WIDTH-1:0] core_read_data_b,
  input duhbp_pkg::duhbp_chan_status_type status_a,
  input duhbp_pkg::duhbp_chan_status_type status_b,
  output logic chan_a_irq,
  output logic chan_a_irq_oe,
  output logic chan_b_irq,
  output logic chan_b_irq_oe,
  output logic chan_a_aux_out_n,
  output logic chan_b_aux_out_n,
  output logic chan_a_tx_ready_n,
  output logic chan_a_rx_ready_n,
  output logic chan_b_tx_ready_n,
  output logic chan_b_rx_ready_n
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic strobe_mode;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic cs_fall;
  logic cs_rise;
  logic sel_a;
  logic sel_b;
  logic sel_any;
  logic sel_chan;
  logic rw_read;
  logic start_read;
  logic start_write;
  logic end_read;
  logic end_write;
  duhbp_pkg::duhbp_state_type state;
  duhbp_pkg::duhbp_state_type next_state;
  logic chan;
  logic [ADDR_WIDTH-1:0] addr_hold;
  logic [DATA_WIDTH-1:0] next_data;

  assign strobe_mode = (bus_style == duhbp_pkg::BUS_STROBE); // see [RULE1]
  assign sel_a = ~chan_a_select_n; // see [RULE8]
  assign sel_b = ~chan_b_select_n; // see [RULE9]
  // both selects low in strobe mode: channel A wins, avoids bus contention
  assign sel_any = strobe_mode ? (sel_a | sel_b) : ~chan_a_select_n; // see [RULE10]
  assign sel_chan = strobe_mode ? (sel_a ? duhbp_pkg::CHAN_A : duhbp_pkg::CHAN_B)
                                : chan_b_select_n; // see [RULE11]
  assign rw_read = (write_strobe_n == duhbp_pkg::DIR_READ); // see [RULE7]

  duhbp_edge #(.IDLE(1'b1)) u_rd_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(read_strobe_n),
    .fall(rd_fall),
    .rise(rd_rise)
  );

  duhbp_edge #(.IDLE(1'b1)) u_wr_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(write_strobe_n),
    .fall(wr_fall),
    .rise(wr_rise)
  );

  duhbp_edge #(.IDLE(1'b1)) u_cs_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(chan_a_select_n),
    .fall(cs_fall),
    .rise(cs_rise)
  );

  // read strobe ignored in read/write-line mode
  assign start_read = strobe_mode ? (rd_fall & sel_any)
                                  : (cs_fall & rw_read); // see [RULE2] [RULE4]
  assign start_write = strobe_mode ? (wr_fall & sel_any)
                                   : (cs_fall & ~rw_read); // see [RULE5]
  assign end_read = strobe_mode ? rd_rise : cs_rise; // see [RULE3]
  assign end_write = strobe_mode ? wr_rise : cs_rise; // see [RULE6]

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      duhbp_pkg::DUHBP_IDLE: begin
        if (start_read) begin
          next_state = duhbp_pkg::DUHBP_READ;
        end else if (start_write) begin
          next_state = duhbp_pkg::DUHBP_WRITE;
        end
      end
      duhbp_pkg::DUHBP_READ: begin
        if (end_read) begin
          next_state = duhbp_pkg::DUHBP_IDLE;
        end
      end
      duhbp_pkg::DUHBP_WRITE: begin
        if (end_write) begin
          next_state = duhbp_pkg::DUHBP_IDLE;
        end
      end
      default: begin
        next_state = duhbp_pkg::DUHBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= duhbp_pkg::DUHBP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // channel and address latched at the start of the cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan <= duhbp_pkg::CHAN_A;
      addr_hold <= '0;
    end else if (state == duhbp_pkg::DUHBP_IDLE && (start_read || start_write)) begin
      chan <= sel_chan;
      addr_hold <= addr; // see [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // data bus
  // ----------------------------------------------------------------
  assign next_data = (chan == duhbp_pkg::CHAN_B) ? core_read_data_b : core_read_data_a;

  // byte reloaded every cycle of the read phase until the rise, then held so host can sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= duhbp_pkg::DATA_RESET;
    end else if (state == duhbp_pkg::DUHBP_READ && !end_read) begin
      data_out <= next_data; // see [RULE2]
    end
  end

  // drive only after the byte is loaded, release on strobe rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= (state == duhbp_pkg::DUHBP_READ) && !end_read; // see [RULE19]
    end
  end

  // read pulse once core sees the address; write on strobe release
  assign core_read = (state == duhbp_pkg::DUHBP_READ) && !data_oe && !end_read;
  assign core_write = (state == duhbp_pkg::DUHBP_WRITE) && end_write; // see [RULE6]
  assign core_access.chan = chan;
  assign core_access.addr = addr_hold;
  assign core_access.data = data_in;

  // ----------------------------------------------------------------
  // interrupt and ready pins
  // ----------------------------------------------------------------
  duhbp_irq_out u_irq_a (
    .open_drain(~strobe_mode), // see [RULE13]
    .irq(status_a.irq),
    .irq_output_enable_bit(status_a.irq_output_enable_bit), // see [RULE12] [RULE15]
    .irq_out(chan_a_irq),
    .irq_oe(chan_a_irq_oe),
    .aux_out_n(chan_a_aux_out_n)
  );

  duhbp_irq_out u_irq_b (
    .open_drain(1'b0),
    .irq(status_b.irq),
    .irq_output_enable_bit(status_b.irq_output_enable_bit), // see [RULE14] [RULE15]
    .irq_out(chan_b_irq),
    .irq_oe(chan_b_irq_oe),
    .aux_out_n(chan_b_aux_out_n)
  );

  // ready levels already follow fifo mode inside the core
  assign chan_a_tx_ready_n = ~status_a.tx_ready; // see [RULE16] [RULE21]
  assign chan_a_rx_ready_n = ~status_a.rx_ready; // see [RULE17]
  assign chan_b_tx_ready_n = ~status_b.tx_ready; // see [RULE16]
  assign chan_b_rx_ready_n = ~status_b.rx_ready; // see [RULE17]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence rd_start_s;
    state == duhbp_pkg::DUHBP_IDLE && start_read;
  endsequence

  // core fetch first, bus driven one cycle later
  sequence rd_load_s;
    core_read ##1 data_oe;
  endsequence

  AST_READ_DRIVES: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE2]
    rd_start_s ##1 !end_read ##1 !end_read |-> ##0 data_oe && data_out == $past(next_data))
    else $error("read byte not driven");

  AST_READ_RELEASE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE3]
    state == duhbp_pkg::DUHBP_READ && end_read |=> !data_oe)
    else $error("bus not released");

  AST_WRITE_ON_RISE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE6]
    core_write |-> end_write && $past(state) != duhbp_pkg::DUHBP_READ)
    else $error("write not on rise");

  AST_WRITE_START: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE5]
    strobe_mode && state == duhbp_pkg::DUHBP_IDLE && wr_fall && sel_any && !start_read
    |=> state == duhbp_pkg::DUHBP_WRITE)
    else $error("write cycle not begun");

  AST_RW_IGNORES_RD: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE4]
    !strobe_mode && state == duhbp_pkg::DUHBP_IDLE && !cs_fall |=> state == duhbp_pkg::DUHBP_IDLE)
    else $error("read strobe used in rw mode");

  AST_CHAN_B_ADDR: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE11]
    !strobe_mode && state == duhbp_pkg::DUHBP_IDLE && cs_fall |=> chan == $past(chan_b_select_n))
    else $error("channel bit wrong");

  AST_STROBE_CHAN: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE8]
    strobe_mode && state == duhbp_pkg::DUHBP_IDLE && (start_read || start_write)
    |=> chan == ($past(chan_a_select_n) ? duhbp_pkg::CHAN_B : duhbp_pkg::CHAN_A))
    else $error("strobe channel wrong");

  AST_IRQ_A_MODE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE13]
    !strobe_mode |-> !chan_a_irq && (chan_a_irq_oe == status_a.irq))
    else $error("shared irq not open drain");

  AST_IRQ_B_EN: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE14]
    chan_b_irq_oe == status_b.irq_output_enable_bit && chan_b_aux_out_n != chan_b_irq_oe)
    else $error("irq b enable wrong");

  AST_READ_LOAD: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE2]
    rd_start_s ##1 !end_read |-> rd_load_s)
    else $error("read fetch order wrong");

  AST_IRQ_A_EN: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE12]
    strobe_mode |-> chan_a_irq == status_a.irq
      && chan_a_irq_oe == status_a.irq_output_enable_bit
      && chan_a_aux_out_n != status_a.irq_output_enable_bit)
    else $error("irq a enable wrong");

  AST_READY_PINS: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE16] [RULE17]
    {chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n}
      == ~{status_a.tx_ready, status_a.rx_ready, status_b.tx_ready, status_b.rx_ready})
    else $error("ready pins wrong");

  AST_NO_SELECT: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE8] [RULE9]
    strobe_mode && state == duhbp_pkg::DUHBP_IDLE && !sel_any
    |=> state == duhbp_pkg::DUHBP_IDLE)
    else $error("access without select taken");

  AST_BUS_TURN: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE19]
    data_oe |-> state == duhbp_pkg::DUHBP_READ)
    else $error("bus driven outside read");

  AST_WRITE_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE6]
    core_write |=> !core_write && state == duhbp_pkg::DUHBP_IDLE)
    else $error("write pulse too long");

endmodule : duhbp_port

// [testbench/duhbp_host_model.sv]
// Purpose: host processor on the 8-bit parallel bus of the port
// Assumes: bus style held static while an access runs
// Notes: hold sets how long the host keeps its strobe low
`timescale 1ns/100ps
module duhbp_host_model (
  input wire logic clk,
  input wire logic bus_style,
  input wire logic [7:0] bus,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic [2:0] addr,
  output logic [7:0] host_data,
  output logic host_oe
);
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    addr = 3'h0;
    host_data = 8'h00;
    host_oe = 1'b0;
  end

  // nosel keeps channel A select idle, and channel B select too in strobe style, so the port must ignore the access
  task automatic access(input logic wr, input logic ch, input logic nosel,
      input logic [2:0] a, input logic [7:0] d, input int hold, output logic [7:0] q);
    @(posedge clk);
    #1;
    addr = a;
    host_data = d;
    host_oe = wr;
    if (bus_style) begin
      chan_a_select_n = nosel | ch;
      chan_b_select_n = nosel | ~ch;
    end else begin
      write_strobe_n = ~wr;
      chan_b_select_n = ch;
    end
    @(posedge clk);
    #1;
    if (!bus_style) chan_a_select_n = nosel;
    else if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (hold) @(posedge clk);
    @(posedge clk);
    #1;
    // byte taken as the strobe rises, while the port still drives it
    q = bus;
    read_strobe_n = 1'b1;
    if (bus_style) write_strobe_n = 1'b1;
    else chan_a_select_n = 1'b1;
    // write data held one more edge: the port samples it when it sees the rise
    @(posedge clk);
    #1;
    host_oe = 1'b0;
    write_strobe_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
  endtask : access
endmodule : duhbp_host_model

// [testbench/dual_uart_host_bus_port_tb_top.sv]
// Purpose: self-checking bench of the host bus port
// Assumes: core registers modelled as two arrays of eight bytes
// Notes: undriven data bus shows a pattern that moves every cycle
`timescale 1ns/100ps
module dual_uart_host_bus_port_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_style = 1'b1;
  int err_count = 0;
  int checks = 0;
  int rd_pulses = 0;
  int wr_pulses = 0;
  logic [7:0] cyc = 8'h00;
  logic [7:0] mem [2][8];
  logic [7:0] exp_mem [2][8];
  duhbp_pkg::duhbp_chan_status_type status_a = '0;
  duhbp_pkg::duhbp_chan_status_type status_b = '0;
  duhbp_pkg::duhbp_access_type core_access;
  logic rs_n, ws_n, csa_n, csb_n, host_oe, data_oe, core_read, core_write;
  logic [2:0] haddr;
  logic [7:0] hdata, data_out;
  logic a_irq, a_oe, b_irq, b_oe, a_aux, b_aux, a_tx, a_rx, b_tx, b_rx;
  wire logic [7:0] bus = data_oe ? data_out : (host_oe ? hdata : cyc);
  wire logic [7:0] rd_a = mem[0][core_access.addr];
  wire logic [7:0] rd_b = mem[1][core_access.addr];

  always #2.5 clk = ~clk;

  // core side: register file written on the port's one-cycle write pulse
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    if (core_read) rd_pulses <= rd_pulses + 1;
    if (core_write) wr_pulses <= wr_pulses + 1;
    if (core_write) mem[core_access.chan][core_access.addr] <= core_access.data;
  end

  duhbp_host_model host (.clk(clk), .bus_style(bus_style), .bus(bus),
    .read_strobe_n(rs_n), .write_strobe_n(ws_n), .chan_a_select_n(csa_n),
    .chan_b_select_n(csb_n), .addr(haddr), .host_data(hdata), .host_oe(host_oe));

  duhbp_port DUT (.clk(clk), .reset_n(reset_n), .bus_style(bus_style),
    .read_strobe_n(rs_n), .write_strobe_n(ws_n), .chan_a_select_n(csa_n),
    .chan_b_select_n(csb_n), .addr(haddr), .data_in(bus), .data_out(data_out),
    .data_oe(data_oe), .core_read(core_read), .core_write(core_write),
    .core_access(core_access), .core_read_data_a(rd_a), .core_read_data_b(rd_b),
    .status_a(status_a), .status_b(status_b), .chan_a_irq(a_irq), .chan_a_irq_oe(a_oe),
    .chan_b_irq(b_irq), .chan_b_irq_oe(b_oe), .chan_a_aux_out_n(a_aux),
    .chan_b_aux_out_n(b_aux), .chan_a_tx_ready_n(a_tx), .chan_a_rx_ready_n(a_rx),
    .chan_b_tx_ready_n(b_tx), .chan_b_rx_ready_n(b_rx));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_status(input logic style);
    logic [15:0] exp;
    logic [15:0] seen;
    bus_style = style;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      status_a = duhbp_pkg::duhbp_chan_status_type'(i[3:0]);
      status_b = duhbp_pkg::duhbp_chan_status_type'(~i[3:0]);
      #1;
      exp = {6'h00, style & status_a.irq,
        style ? status_a.irq_output_enable_bit : status_a.irq,
        ~status_a.irq_output_enable_bit, ~status_a.tx_ready, ~status_a.rx_ready,
        status_b.irq, status_b.irq_output_enable_bit, ~status_b.irq_output_enable_bit,
        ~status_b.tx_ready, ~status_b.rx_ready};
      seen = {6'h00, a_irq, a_oe, a_aux, a_tx, a_rx, b_irq, b_oe, b_aux, b_tx, b_rx};
      check(seen, exp, "irq or ready pins");
    end
    $display("test status style %0d done", style);
  endtask : test_status

  // writes every register of both channels, two writes with no select, then reads all back
  task automatic test_bus(input logic style, input int hold);
    logic [7:0] q;
    int w0;
    int r0;
    bus_style = style;
    w0 = wr_pulses;
    r0 = rd_pulses;
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) begin
        exp_mem[c][a] = {style, hold[2:0], c[0], a[2:0]};
        host.access(1'b1, c[0], 1'b0, a[2:0], exp_mem[c][a], hold, q);
      end
    end
    host.access(1'b1, 1'b0, 1'b1, 3'h5, 8'hff, hold, q);
    host.access(1'b1, 1'b1, 1'b1, 3'h2, 8'hff, hold, q);
    check(16'(wr_pulses - w0), 16'h0010, "write pulses");
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) begin
        host.access(1'b0, c[0], 1'b0, a[2:0], 8'h00, hold, q);
        check({8'h00, q}, {8'h00, exp_mem[c][a]}, "read back");
        check({15'h0000, data_oe}, 16'h0000, "bus not released");
      end
    end
    check(16'(rd_pulses - r0), 16'h0010, "read pulses");
    $display("test bus style %0d hold %0d done", style, hold);
  endtask : test_bus

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("wrong value at %0t: watchdog ran out", $time);
    conclude();
  end

  initial begin
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) begin
        mem[c][a] = 8'h00;
        exp_mem[c][a] = 8'h00;
      end
    end
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    #1;
    check({13'h0000, data_oe, a_aux, b_aux}, 16'h0003, "state after reset");
    test_status(1'b1);
    test_bus(1'b1, 2);
    test_bus(1'b1, 6);
    test_bus(1'b0, 2);
    test_status(1'b0);
    test_bus(1'b0, 6);
    conclude();
  end
endmodule : dual_uart_host_bus_port_tb_top
